// file: design/sbt_tap.sv
// Purpose: Boundary-scan test access port of a burst memory
// Assumes: Test clock far slower than CLK, sampled and edge-detected
// Notes: Observe only; the port never drives the memory core
`default_nettype none

// What this block does
// [RULE_01] Step controller on TMS at clock rise
// [RULE_02] Shift TDI into selected register top bit
// [RULE_03] Update TDO on falling edge, LSB
// [RULE_04] State and instruction pick one register
// [RULE_05] Five TMS-high edges reset, IDCODE held
// [RULE_06] Test reset leaves memory operation alone
// [RULE_07] Power-up reset floats TDO
// [RULE_08] Three-bit instruction, loaded only in path
// [RULE_09] Instruction capture loads 01 low bits
// [RULE_10] New instruction active only at update
// [RULE_11] IDCODE default at power-up and reset
// [RULE_12] One-bit bypass, cleared under BYPASS
// [RULE_13] Boundary chain 70 or 51 bits
// [RULE_14] Capture pads, then shift boundary chain
// [RULE_15] Identification code captured, LSB first
// [RULE_16] All-zero is sample plus outputs floated
// [RULE_17] SAMPLE-Z floats outputs, shifts chain
// [RULE_18] Sample snapshots pads at capture
// [RULE_19] Data update does nothing, no preload
// [RULE_20] Port only observes, never drives core
// [RULE_21] Tester holds inputs stable during capture
// [RULE_22] Bypass stage in path under BYPASS
// [RULE_23] Codes 000 EXTEST, 001 IDCODE, 010 SAMPLE-Z
// [RULE_24] Identification bit 0 is one
// [RULE_25] Sixteen-state controller
module sbt_tap (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Test pins
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    // Pad ring observation
    input wire logic [sbt_pkg::BSR_W-1:0] PAD_IN,
    input wire logic PAD_VALID,
    output logic PAD_READY,
    // Output float override
    output logic OUT_HIZ,
    // Test state
    output logic TEST_RESET
);
    // ----------------------------------------------------------------
    // Reset release and pin sampling
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [2:0] tck_s1_q, tck_s2_q;
    logic tck_prev_q;
    logic rise, fall;

    // Reset release synchroniser
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Two-stage sampling of TCK, TMS, TDI
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tck_s1_q <= 3'h3; // TCK idles low, TMS and TDI high
            tck_s2_q <= 3'h3; // No false edge after reset
            tck_prev_q <= 1'b0;
        end
        else
        begin
            tck_s1_q <= {TCK, TMS, TDI};
            tck_s2_q <= tck_s1_q;
            tck_prev_q <= tck_s2_q[2];
        end
    end
    wire tck_s = tck_s2_q[2];
    wire tms_s = tck_s2_q[1];
    wire tdi_s = tck_s2_q[0];
    assign rise = tck_s & ~tck_prev_q;
    assign fall = ~tck_s & tck_prev_q;

    // ----------------------------------------------------------------
    // Controller
    // ----------------------------------------------------------------
    sbt_pkg::sbt_state_e st_q, st_d;

    // Next state from TMS
    always_comb
    begin
        unique case (st_q)
            sbt_pkg::ST_RESET:  st_d = tms_s ? sbt_pkg::ST_RESET : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_IDLE:   st_d = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_DR: st_d = tms_s ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
            sbt_pkg::ST_CAP_DR: st_d = tms_s ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
            sbt_pkg::ST_SH_DR:  st_d = tms_s ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
            sbt_pkg::ST_EX1_DR: st_d = tms_s ? sbt_pkg::ST_UP_DR : sbt_pkg::ST_PA_DR;
            sbt_pkg::ST_PA_DR:  st_d = tms_s ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PA_DR;
            sbt_pkg::ST_EX2_DR: st_d = tms_s ? sbt_pkg::ST_UP_DR : sbt_pkg::ST_SH_DR;
            sbt_pkg::ST_UP_DR:  st_d = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
            sbt_pkg::ST_SEL_IR: st_d = tms_s ? sbt_pkg::ST_RESET : sbt_pkg::ST_CAP_IR;
            sbt_pkg::ST_CAP_IR: st_d = tms_s ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
            sbt_pkg::ST_SH_IR:  st_d = tms_s ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
            sbt_pkg::ST_EX1_IR: st_d = tms_s ? sbt_pkg::ST_UP_IR : sbt_pkg::ST_PA_IR;
            sbt_pkg::ST_PA_IR:  st_d = tms_s ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PA_IR;
            sbt_pkg::ST_EX2_IR: st_d = tms_s ? sbt_pkg::ST_UP_IR : sbt_pkg::ST_SH_IR;
            sbt_pkg::ST_UP_IR:  st_d = tms_s ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
        endcase
    end

    // [RULE_01] [RULE_25] state step on rise
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= sbt_pkg::ST_RESET;
        else if (rise)
            st_q <= st_d;
    end

    // ----------------------------------------------------------------
    // Instruction decode and path select
    // ----------------------------------------------------------------
    logic [2:0] ir_sh_q, ir_q;
    logic byp_q;
    logic [sbt_pkg::ID_W-1:0] id_q;
    logic [sbt_pkg::BSR_W-1:0] bsr_q;

    // [RULE_23] [RULE_16] [RULE_17] code decode
    wire ins_id = (ir_q == sbt_pkg::INS_IDCODE);
    wire ins_float = (ir_q == sbt_pkg::INS_EXTEST) || (ir_q == sbt_pkg::INS_SAMPZ);
    wire ins_scan = ins_float || (ir_q == sbt_pkg::INS_SAMPLE);
    wire ins_byp = !ins_id && !ins_scan;
    wire in_sh_dr = (st_q == sbt_pkg::ST_SH_DR);
    wire in_sh_ir = (st_q == sbt_pkg::ST_SH_IR);
    wire in_cap_dr = (st_q == sbt_pkg::ST_CAP_DR);
    // [RULE_04] one register feeds TDO
    wire tdo_bit = in_sh_ir ? ir_sh_q[0] :
                   ins_id ? id_q[0] :
                   ins_scan ? bsr_q[0] : byp_q;

    // ----------------------------------------------------------------
    // Pad capture buffer (two entries)
    // ----------------------------------------------------------------
    logic [sbt_pkg::BSR_W-1:0] buf_q [2];
    logic [1:0] buf_cnt_q;
    logic buf_rd_q, buf_wr_q;
    logic [sbt_pkg::BSR_W-1:0] pad_snap_q;
    // [RULE_21] latest stable snapshot held
    wire buf_push = PAD_VALID && PAD_READY && (buf_cnt_q != 2'h2);
    wire buf_pop = (buf_cnt_q != 2'h0);

    // Buffer write, read and count
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_cnt_q <= 2'h0;
            buf_rd_q <= 1'b0;
            buf_wr_q <= 1'b0;
            pad_snap_q <= '0;
        end
        else
        begin
            if (buf_push)
                buf_wr_q <= ~buf_wr_q;
            if (buf_pop)
            begin
                buf_rd_q <= ~buf_rd_q;
                pad_snap_q <= buf_q[buf_rd_q];
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // Buffer storage
    always_ff @(posedge CLK)
    begin
        if (buf_push)
            buf_q[buf_wr_q] <= PAD_IN;
    end

    // ----------------------------------------------------------------
    // Serial registers
    // ----------------------------------------------------------------
    // [RULE_08] [RULE_09] [RULE_10] instruction shift
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            ir_sh_q <= sbt_pkg::INS_IDCODE;
        else if (rise && st_q == sbt_pkg::ST_CAP_IR)
            ir_sh_q <= {1'b0, sbt_pkg::IR_CAPTURE_PAT};
        else if (rise && in_sh_ir)
            ir_sh_q <= {tdi_s, ir_sh_q[2:1]};
    end

    // [RULE_05] [RULE_11] [RULE_10] active instruction
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            ir_q <= sbt_pkg::INS_IDCODE;
        else if (st_q == sbt_pkg::ST_RESET)
            ir_q <= sbt_pkg::INS_IDCODE;
        else if (rise && st_q == sbt_pkg::ST_UP_IR)
            ir_q <= ir_sh_q;
    end

    // [RULE_12] [RULE_22] [RULE_02] bypass stage
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            byp_q <= 1'b0;
        else if (rise && ins_byp && in_cap_dr)
            byp_q <= 1'b0;
        else if (rise && ins_byp && in_sh_dr)
            byp_q <= tdi_s;
    end

    // [RULE_15] [RULE_24] identification register
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            id_q <= sbt_pkg::ID_CODE;
        else if (rise && ins_id && in_cap_dr)
            id_q <= sbt_pkg::ID_CODE;
        else if (rise && ins_id && in_sh_dr)
            id_q <= {tdi_s, id_q[sbt_pkg::ID_W-1:1]};
    end

    // [RULE_13] [RULE_14] [RULE_18] [RULE_19] boundary chain
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            bsr_q <= '0;
        else if (rise && ins_scan && in_cap_dr)
            bsr_q <= pad_snap_q;
        else if (rise && ins_scan && in_sh_dr)
            bsr_q <= {tdi_s, bsr_q[sbt_pkg::BSR_W-1:1]};
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // [RULE_03] [RULE_07] TDO on fall
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            TDO <= 1'b0;
            TDO_OE <= 1'b0;
        end
        else if (fall)
        begin
            TDO <= tdo_bit;
            TDO_OE <= in_sh_dr || in_sh_ir;
        end
    end

    // [RULE_06] [RULE_20] float only, no drive
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            OUT_HIZ <= 1'b0;
            TEST_RESET <= 1'b1;
            PAD_READY <= 1'b0;
        end
        else
        begin
            OUT_HIZ <= ins_float && (st_q != sbt_pkg::ST_RESET);
            TEST_RESET <= (st_q == sbt_pkg::ST_RESET);
            PAD_READY <= (buf_cnt_q == 2'h0);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [2:0] tms_hi_cnt_q;
    // Count of consecutive TMS-high rises, saturating
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            tms_hi_cnt_q <= 3'h0;
        else if (rise)
            tms_hi_cnt_q <= tms_s ? ((tms_hi_cnt_q == 3'h5) ? 3'h5 : tms_hi_cnt_q + 3'h1) : 3'h0;
    end

    AST_FIVE_RESET: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_05]
        tms_hi_cnt_q == 3'h5 |-> st_q == sbt_pkg::ST_RESET)
        else $error("five high TMS edges did not reset");
    AST_IDCODE_IN_RESET: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_11]
        st_q == sbt_pkg::ST_RESET |=> ir_q == sbt_pkg::INS_IDCODE)
        else $error("instruction not IDCODE in reset");
    AST_STEP_ON_RISE: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_01]
        !rise |=> $stable(st_q))
        else $error("state moved without clock rise");
    AST_TDO_ON_FALL: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_03]
        !fall |=> $stable(TDO))
        else $error("TDO changed off falling edge");
    AST_IR_CAPTURE: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_09]
        rise && st_q == sbt_pkg::ST_CAP_IR |=> ir_sh_q[1:0] == 2'h1)
        else $error("instruction capture pattern wrong");
    AST_IR_UPDATE_ONLY: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_10]
        $changed(ir_q) |-> $past(st_q) inside {sbt_pkg::ST_UP_IR, sbt_pkg::ST_RESET})
        else $error("instruction changed outside update");
    AST_ID_CAPTURE: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_15]
        rise && ins_id && in_cap_dr |=> id_q == sbt_pkg::ID_CODE && id_q[0])
        else $error("identification capture wrong");
    AST_FLOAT: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_16]
        ins_float && st_q != sbt_pkg::ST_RESET |=> OUT_HIZ)
        else $error("outputs not floated");
    AST_NO_PRELOAD: assert property (@(posedge CLK) disable iff (!rst_n) // [RULE_19]
        st_q == sbt_pkg::ST_UP_DR |=> $stable(bsr_q))
        else $error("data update changed chain");
endmodule : sbt_tap
`default_nettype wire

// file: design/sbt_pkg.sv
// Purpose: Constants and types for the memory boundary-scan test port
// Assumes: Test clock sampled by a 10 MHz system clock
// Notes: Identification fields other than the presence bit are arbitrary
`default_nettype none
package sbt_pkg;
    // ----------------------------------------------------------------
    // Register widths, reset edge count and capture pattern
    // ----------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_WIDE = 70;
    localparam int BSR_NARROW = 51;
    localparam int BSR_W = BSR_WIDE;
    localparam int TMS_RESET_EDGES = 5;
    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // ----------------------------------------------------------------
    // Identification code fields (values arbitrary, bit 0 fixed)
    // ----------------------------------------------------------------
    localparam logic [3:0] ID_REV = 4'h0;
    localparam logic [4:0] ID_DEPTH = 5'h06;
    localparam logic [4:0] ID_WIDTH = 5'h04;
    localparam logic [5:0] ID_RSVD = 6'h00;
    localparam logic [10:0] ID_MAKER = 11'h155; // arbitrary value
    localparam logic ID_PRESENT = 1'b1;
    localparam logic [31:0] ID_CODE = {ID_REV, ID_DEPTH, ID_WIDTH, ID_RSVD, ID_MAKER, ID_PRESENT};

    // ----------------------------------------------------------------
    // Controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
        ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf
    } sbt_state_e;
endpackage : sbt_pkg
`default_nettype wire

// file: sim/sbt_tester.sv
// Purpose: Behavioural boundary-scan tester driving the test pins
// Assumes: Pins change on falling CLK, test clock period 800 ns
// Notes: Test clock stands low between operations
`default_nettype none
module sbt_tester (
    // System clock for pacing
    input wire logic clk,
    // Test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle pin levels from time zero
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One test clock period; output is read just before the rise
    task automatic step(input logic m, input logic d, output logic q, output logic oe);
        @(negedge clk);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        // Undriven TDO reads as the inverse of its last bit
        q = tdo_oe ? tdo : ~tdo;
        oe = tdo_oe;
        tck = 1'b1;
        repeat (3) @(negedge clk);
        tck = 1'b0;
    endtask : step

    task automatic reset5();
        logic q;
        logic oe;
        repeat (5) step(1'b1, 1'b1, q, oe);
    endtask : reset5
endmodule : sbt_tester
`default_nettype wire

// file: sim/tb_sram_boundary_scan_tap.sv
// Purpose: Self-checking bench for the memory boundary-scan test port
// Assumes: Tester model paces the test clock from CLK
// Notes: Expected scan data comes from a behavioural register model
`default_nettype none
module tb_sram_boundary_scan_tap;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Signals, counters and instances
    // ----------------------------------------------------------------
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic TCK;
    logic TMS;
    logic TDI;
    logic TDO;
    logic TDO_OE;
    logic [sbt_pkg::BSR_W-1:0] PAD_IN = 70'h0;
    logic PAD_VALID = 1'b0;
    logic PAD_READY;
    logic OUT_HIZ;
    logic TEST_RESET;
    logic q_b;
    logic oe_b;
    int bad_count = 0;
    int checked = 0;
    // Model of pad words taken by the port, newest last
    logic [69:0] pad_q [$];

    // System clock, 100 ns period
    always #50 CLK = ~CLK;

    sbt_tap u_sbt_tap (.CLK(CLK), .RST_B(RST_B), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
        .TDO_OE(TDO_OE), .PAD_IN(PAD_IN), .PAD_VALID(PAD_VALID), .PAD_READY(PAD_READY),
        .OUT_HIZ(OUT_HIZ), .TEST_RESET(TEST_RESET));
    sbt_tester u_sbt_tester (.clk(CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO),
        .tdo_oe(TDO_OE));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic st(input logic m, input logic d);
        u_sbt_tester.step(m, d, q_b, oe_b);
    endtask : st

    // Walk from idle into a shift state
    task automatic enter(input logic ir);
        st(1'b1, 1'b0);
        if (ir)
            st(1'b1, 1'b0);
        st(1'b0, 1'b0);
        st(1'b0, 1'b0);
    endtask : enter

    // Shift n bits, leaving on the last one
    task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = 128'h0;
        for (int i = 0; i < n; i++)
        begin
            st(i == n - 1, din[i]);
            dout[i] = q_b;
            check(oe_b, 1'b1);
        end
    endtask : scan

    task automatic read_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
        enter(1'b0);
        scan(n, din, dout);
        st(1'b1, 1'b0);
        st(1'b0, 1'b0);
    endtask : read_dr

    task automatic load_ir(input logic [2:0] code);
        logic [127:0] dout;
        logic prev;
        prev = OUT_HIZ;
        enter(1'b1);
        scan(3, {125'h0, code}, dout);
        check(dout[1:0], 2'h1);
        check(OUT_HIZ, prev);
        st(1'b1, 1'b0);
        st(1'b0, 1'b0);
        repeat (4) @(negedge CLK);
        check(OUT_HIZ, code == 3'h0 || code == 3'h2);
    endtask : load_ir

    // Offer one pad word, holding it until taken
    task automatic offer(input logic [69:0] w);
        int n;
        n = 0;
        @(negedge CLK);
        PAD_IN = w;
        PAD_VALID = 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PAD_READY !== 1'b1 && n < 40);
        pad_q.push_back(w);
        check(n < 40, 1'b1);
    endtask : offer

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [127:0] din;
        logic [127:0] dout;
        logic [127:0] r;
        logic [69:0] pad;
        logic [2:0] codes [8];
        int len;
        codes = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3, 3'h5, 3'h6};
        void'($urandom(32'h1504));
        repeat (12) @(negedge CLK);
        RST_B = 1'b1;
        repeat (6) @(negedge CLK);
        check(TDO_OE, 1'b0);
        check(OUT_HIZ, 1'b0);
        check(TEST_RESET, 1'b1);
        st(1'b0, 1'b0);
        repeat (4) @(negedge CLK);
        check(TEST_RESET, 1'b0);
        din = {64'h0, $urandom, $urandom};
        read_dr(64, din, dout);
        check(dout[31:0], sbt_pkg::ID_CODE);
        check(dout[0], 1'b1);
        check(dout[63:32], din[31:0]);
        foreach (codes[k])
        begin
            load_ir(codes[k]);
            pad = 70'({$urandom, $urandom, $urandom});
            offer(70'({$urandom, $urandom, $urandom}));
            offer(pad);
            @(negedge CLK);
            PAD_VALID = 1'b0;
            PAD_IN = ~pad;
            repeat (4) @(negedge CLK);
            len = (codes[k] == 3'h1) ? 32 : (codes[k] inside {3'h0, 3'h2, 3'h4}) ? 70 : 1;
            r = (len == 32) ? 128'(sbt_pkg::ID_CODE) : (len == 70) ? 128'(pad_q[$]) : 128'h0;
            repeat (2)
            begin
                din = {$urandom, $urandom, $urandom, $urandom};
                read_dr(72, din, dout);
                check(dout[71:0], 72'((din << len) | r));
                check(dout[71:0], 72'((din << len) | r));
                check(OUT_HIZ, codes[k] == 3'h0 || codes[k] == 3'h2);
            end
        end
        load_ir(3'h0);
        enter(1'b0);
        u_sbt_tester.reset5();
        repeat (5) @(negedge CLK);
        check(TEST_RESET, 1'b1);
        check(OUT_HIZ, 1'b0);
        st(1'b0, 1'b0);
        read_dr(32, 128'h0, dout);
        check(dout[31:0], sbt_pkg::ID_CODE);
        summarize();
    end

    // Hang guard, about three and a half times the expected run
    initial
    begin
        repeat (40000) @(posedge CLK);
        bad_count++;
        summarize();
    end
endmodule : tb_sram_boundary_scan_tap
`default_nettype wire
